// ### common/gdfp_defines.vh
// constants for the gate driver fault protection block
`ifndef GDFP_DEFINES_VH
`define GDFP_DEFINES_VH

`define GDFP_CLK_MHZ 25
// desaturation digital filter, ns
`define GDFP_DESAT_FILT_NS 1000
`define GDFP_DESAT_FILT_CYC ((`GDFP_DESAT_FILT_NS * `GDFP_CLK_MHZ + 500) / 1000)
// gate-supply undervoltage filter, ns
`define GDFP_UV_FILT_NS 700
`define GDFP_UV_FILT_CYC ((`GDFP_UV_FILT_NS * `GDFP_CLK_MHZ + 500) / 1000)
// active gate-off after undervoltage, ns
`define GDFP_UV_OFF_NS 8000
`define GDFP_UV_OFF_CYC ((`GDFP_UV_OFF_NS * `GDFP_CLK_MHZ + 500) / 1000)
// charge pump frequency, kHz; half period in cycles
`define GDFP_PUMP_KHZ 130
`define GDFP_PUMP_HALF_CYC ((`GDFP_CLK_MHZ * 1000 + `GDFP_PUMP_KHZ) / (2 * `GDFP_PUMP_KHZ))
// register port
`define GDFP_ADDR_W 4
`define GDFP_REG_STATUS0 4'h0
`define GDFP_REG_MASK 4'h1
`define GDFP_REG_CTRL 4'h2
`define GDFP_REG_TIMING 4'h3
`define GDFP_REG_PHASEERR 4'h4
`define GDFP_REG_CLEAR 4'h5
// status0 bit positions
`define GDFP_ST_OC 0
`define GDFP_ST_DESAT 1
`define GDFP_ST_PHASE 2
`define GDFP_ST_UV 3
// ctrl bits
`define GDFP_CTRL_DESAT_SD 0
`define GDFP_CTRL_PHASE_SD 1
// clear register bits
`define GDFP_CLR_GRP0 0
`define GDFP_CLR_GRP1 1
`define GDFP_CLR_INIT 2
// reset values
`define GDFP_MASK_RST 4'h0
`define GDFP_CTRL_RST 2'h3
`define GDFP_DEAD_RST 8'h05
`define GDFP_BLANK_RST 8'h0a

`endif

// ### logic/gdfp_gate_driver_fault_protection.v
// fault supervision and gate steering for a three-phase predriver
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "gdfp_defines.vh"
// ----------------------------------------------------------------
// Operation
// - one overcurrent comparator and sense amplifier serve all three phases.
// - amplifier above threshold raises overcurrent flag output and latches the fault.
// - latched overcurrent shows in status 0; drives interrupt high if unmasked.
// - overcurrent interrupt holds until fault gone and group-0 clear issued.
// - high-side on only after deadtime started at low-side off.
// - source node low after blanking with high-side on initiates desaturation.
// - desaturation registered after 1.0 us filter; all gates clamped off.
// - condition vanishing before filter expiry discards it and restarts filter.
// - each qualified fault sets a readable status bit.
// - per-source interrupt masks; separate shutdown disables for desat and phase.
// - high-side phase error: commanded on, comparator low after deadtime plus blanking.
// - low-side phase error: commanded on, comparator high after deadtime plus blanking.
// - summary phase flag is OR over phases of high and low errors.
// - phase interrupt holds until fault gone and group-1 clear issued.
// - undervoltage shorter than about 700 ns is ignored.
// - qualified undervoltage drives gates off 8.0 us, then weak hold-off.
// - after recovery low-side follows input; high-side blocked until initialization.
// - after recovery high-side stays high impedance until low-side turned off.
// - hold-off pull-down while logic supply low, reset, or gate supply disabled.
// - charge pump on below regulation threshold, off above threshold plus hysteresis.
// - charge pump switches at 130 kHz while enabled.
// - after any protective fault a fresh initialization is needed.
// - high-side refused until its low-side enabled once after enable.
// ----------------------------------------------------------------
module gdfp_gate_driver_fault_protection
(
    input wire clk,
    input wire reset,
    input wire [`GDFP_ADDR_W-1:0] regAddr,
    input wire [7:0] regWriteData,
    input wire regWrite,
    input wire regRead,
    output reg [7:0] regReadData,
    input wire [2:0] upper_cmd_in,
    input wire [2:0] lower_cmd_in,
    input wire enableIn,
    input wire senseAmpOverThreshold,
    input wire [2:0] desatComparator,
    input wire [2:0] phaseComparatorHigh,
    input wire gateSupplyUnder,
    input wire gate_supply_disable_level,
    input wire logicSupplyLow,
    input wire gateSupplyBelowReg,
    input wire gateSupplyAboveHyst,
    output reg overcurrent_flag_out,
    output reg irqOut,
    output reg [2:0] upper_gate_out,
    output reg [2:0] lower_gate_out,
    output reg [2:0] upperGateHighZ,
    output reg [2:0] activeOff,
    output reg holdOff,
    output reg chargePumpClk
);

// ----------------------------------------------------------------
// registers and state
// ----------------------------------------------------------------
reg [3:0] status0;
reg [3:0] irqMask;
reg [1:0] ctrl;
reg [7:0] deadCycles;
reg [7:0] blankCycles;
reg [2:0] hsErr;
reg [2:0] lsErr;
reg needInit;
reg [2:0] lsSeen;
reg [2:0] hsWaitLsOff;
reg prevUv;
reg [4:0] uvFilt;
reg [7:0] uvOffCnt;
reg pumpOn;
reg [7:0] pumpCnt;
reg [2:0] prevUpper;
reg [2:0] prevLower;
reg [2:0] upperReq;
reg [2:0] lowerReq;
reg [2:0] desatHit;
reg [8:0] deadCnt [0:2];
reg [8:0] settleCnt [0:2];
reg [4:0] desatCnt [0:2];
wire [2:0] desatRaw;
wire [2:0] desatQualified;
wire [2:0] settleDone;
wire uvQualified;
wire protectDesat;
wire protectPhase;
wire clr0;
wire clr1;
wire initCmd;
wire anyPhaseErr;
wire [2:0] hsSet;
wire [2:0] lsSet;
// gate-off load, cut to the counter width
localparam integer UV_OFF_FULL = `GDFP_UV_OFF_CYC;

assign clr0 = regWrite && regAddr == `GDFP_REG_CLEAR && regWriteData[`GDFP_CLR_GRP0];
assign clr1 = regWrite && regAddr == `GDFP_REG_CLEAR && regWriteData[`GDFP_CLR_GRP1];
assign initCmd = regWrite && regAddr == `GDFP_REG_CLEAR && regWriteData[`GDFP_CLR_INIT];
assign anyPhaseErr = |(hsSet | lsSet);
assign uvQualified = uvFilt == `GDFP_UV_FILT_CYC;
assign protectDesat = status0[`GDFP_ST_DESAT] && ctrl[`GDFP_CTRL_DESAT_SD];
assign protectPhase = status0[`GDFP_ST_PHASE] && ctrl[`GDFP_CTRL_PHASE_SD];

// ----------------------------------------------------------------
// per-phase deadtime, blanking, desaturation and phase check
// ----------------------------------------------------------------
genvar p;
generate
    for (p = 0; p < 3; p = p + 1)
    begin : gPhase
        // desaturation only judged with high-side on and blanking over
        assign settleDone[p] = settleCnt[p] == 9'h000;
        assign desatRaw[p] = upperReq[p] && settleDone[p] && desatComparator[p];
        assign desatQualified[p] = desatCnt[p] == `GDFP_DESAT_FILT_CYC;
        assign hsSet[p] = settleCnt[p] == 9'h001 && upperReq[p] && !phaseComparatorHigh[p];
        assign lsSet[p] = settleCnt[p] == 9'h001 && lowerReq[p] && phaseComparatorHigh[p];
        always @(posedge clk)
        begin
            if (reset)
            begin
                deadCnt[p] <= 9'h000;
                settleCnt[p] <= 9'h000;
                desatCnt[p] <= 5'h00;
                upperReq[p] <= 1'b0;
                lowerReq[p] <= 1'b0;
                hsErr[p] <= 1'b0;
                lsErr[p] <= 1'b0;
            end
            else
            begin
                // leading edge turns complement off and starts deadtime
                if (upper_cmd_in[p] && !prevUpper[p])
                begin
                    lowerReq[p] <= 1'b0;
                    if (lowerReq[p])
                        deadCnt[p] <= {1'b0, deadCycles};
                    settleCnt[p] <= {1'b0, deadCycles} + {1'b0, blankCycles};
                end
                else if (lower_cmd_in[p] && !prevLower[p])
                begin
                    upperReq[p] <= 1'b0;
                    if (upperReq[p])
                        deadCnt[p] <= {1'b0, deadCycles};
                    settleCnt[p] <= {1'b0, deadCycles} + {1'b0, blankCycles};
                end
                else
                begin
                    if (deadCnt[p] != 9'h000)
                        deadCnt[p] <= deadCnt[p] - 9'h001;
                    if (settleCnt[p] != 9'h000)
                        settleCnt[p] <= settleCnt[p] - 9'h001;
                    if (deadCnt[p] == 9'h000 || deadCnt[p] == 9'h001)
                    begin
                        upperReq[p] <= upper_cmd_in[p] && !lower_cmd_in[p];
                        lowerReq[p] <= lower_cmd_in[p] && !upper_cmd_in[p];
                    end
                end
                // a granted side dropping starts the deadtime too
                if (!upper_cmd_in[p])
                begin
                    upperReq[p] <= 1'b0;
                    if (upperReq[p])
                        deadCnt[p] <= {1'b0, deadCycles};
                end
                if (!lower_cmd_in[p])
                begin
                    lowerReq[p] <= 1'b0;
                    if (lowerReq[p])
                        deadCnt[p] <= {1'b0, deadCycles};
                end
                // filter restarts if condition drops
                if (!desatRaw[p])
                    desatCnt[p] <= 5'h00;
                else if (!desatQualified[p])
                    desatCnt[p] <= desatCnt[p] + 5'h01;
                // latched error; a fresh error beats a clear
                if (hsSet[p])
                    hsErr[p] <= 1'b1;
                else if (clr1)
                    hsErr[p] <= 1'b0;
                if (lsSet[p])
                    lsErr[p] <= 1'b1;
                else if (clr1)
                    lsErr[p] <= 1'b0;
            end
        end
    end
endgenerate

// ----------------------------------------------------------------
// fault status, interrupt, register port
// ----------------------------------------------------------------
always @(posedge clk)
begin
    if (reset)
    begin
        status0 <= 4'h0;
        irqMask <= `GDFP_MASK_RST;
        ctrl <= `GDFP_CTRL_RST;
        deadCycles <= `GDFP_DEAD_RST;
        blankCycles <= `GDFP_BLANK_RST;
        regReadData <= 8'h00;
        overcurrent_flag_out <= 1'b0;
        irqOut <= 1'b0;
        prevUpper <= 3'h0;
        prevLower <= 3'h0;
        desatHit <= 3'h0;
    end
    else
    begin
        prevUpper <= upper_cmd_in;
        prevLower <= lower_cmd_in;
        overcurrent_flag_out <= senseAmpOverThreshold;
        // set wins; clear only once the fault is gone
        if (senseAmpOverThreshold)
            status0[`GDFP_ST_OC] <= 1'b1;
        else if (clr0)
            status0[`GDFP_ST_OC] <= 1'b0;
        if (|desatQualified || (|hsSet))
            status0[`GDFP_ST_DESAT] <= 1'b1;
        else if (clr1)
            status0[`GDFP_ST_DESAT] <= 1'b0;
        if (anyPhaseErr)
            status0[`GDFP_ST_PHASE] <= 1'b1;
        else if (clr1)
            status0[`GDFP_ST_PHASE] <= 1'b0;
        if (uvQualified)
            status0[`GDFP_ST_UV] <= 1'b1;
        else if (clr0)
            status0[`GDFP_ST_UV] <= 1'b0;
        if (|desatQualified)
            desatHit <= desatQualified;
        else if (clr1)
            desatHit <= 3'h0;
        irqOut <= |(status0 & irqMask);
        if (regWrite)
        begin
            case (regAddr)
                `GDFP_REG_MASK: irqMask <= regWriteData[3:0];
                `GDFP_REG_CTRL: ctrl <= regWriteData[1:0];
                `GDFP_REG_TIMING: deadCycles <= regWriteData;
                `GDFP_REG_PHASEERR: blankCycles <= regWriteData;
                default: ;
            endcase
        end
        if (regRead)
        begin
            case (regAddr)
                `GDFP_REG_STATUS0: regReadData <= {4'h0, status0};
                `GDFP_REG_MASK: regReadData <= {4'h0, irqMask};
                `GDFP_REG_CTRL: regReadData <= {needInit, pumpOn, 4'h0, ctrl};
                `GDFP_REG_TIMING: regReadData <= deadCycles;
                `GDFP_REG_PHASEERR: regReadData <= {1'b0, desatHit, 1'b0, hsErr | lsErr};
                default: regReadData <= 8'h00;
            endcase
        end
        else
            regReadData <= 8'h00;
    end
end

// ----------------------------------------------------------------
// undervoltage, initialization, gate outputs
// ----------------------------------------------------------------
always @(posedge clk)
begin
    if (reset)
    begin
        uvFilt <= 5'h00;
        uvOffCnt <= 8'h00;
        prevUv <= 1'b0;
        needInit <= 1'b1;
        lsSeen <= 3'h0;
        hsWaitLsOff <= 3'h0;
        upper_gate_out <= 3'h0;
        lower_gate_out <= 3'h0;
        upperGateHighZ <= 3'h0;
        activeOff <= 3'h7;
        holdOff <= 1'b1;
    end
    else
    begin
        if (!gateSupplyUnder)
            uvFilt <= 5'h00;
        else if (!uvQualified)
            uvFilt <= uvFilt + 5'h01;
        prevUv <= uvQualified;
        if (uvQualified && !prevUv)
            uvOffCnt <= UV_OFF_FULL[7:0];
        else if (uvOffCnt != 8'h00)
            uvOffCnt <= uvOffCnt - 8'h01;
        // recovery: high-side floats until low-side turned off
        if (prevUv && !uvQualified)
            hsWaitLsOff <= 3'h7;
        else
            hsWaitLsOff <= hsWaitLsOff & ~(~lowerReq & lsSeen);
        if (protectDesat || protectPhase || uvQualified || !enableIn)
        begin
            needInit <= 1'b1;
            lsSeen <= 3'h0;
        end
        else if (initCmd)
            needInit <= 1'b0;
        else
            lsSeen <= lsSeen | lowerReq;
        holdOff <= logicSupplyLow || gate_supply_disable_level
            || (uvQualified && prevUv && uvOffCnt == 8'h00);
        if (protectDesat || protectPhase || logicSupplyLow || gate_supply_disable_level)
        begin
            upper_gate_out <= 3'h0;
            lower_gate_out <= 3'h0;
            activeOff <= 3'h7;
            upperGateHighZ <= 3'h0;
        end
        else if (uvQualified)
        begin
            upper_gate_out <= 3'h0;
            lower_gate_out <= 3'h0;
            activeOff <= (uvOffCnt != 8'h00 || !prevUv) ? 3'h7 : 3'h0;
            upperGateHighZ <= 3'h0;
        end
        else
        begin
            lower_gate_out <= enableIn ? lowerReq : 3'h0;
            upper_gate_out <= (enableIn && !needInit) ? (upperReq & lsSeen & ~hsWaitLsOff) : 3'h0;
            upperGateHighZ <= hsWaitLsOff;
            activeOff <= 3'h7;
        end
    end
end

// ----------------------------------------------------------------
// charge pump
// ----------------------------------------------------------------
always @(posedge clk)
begin
    if (reset)
    begin
        pumpOn <= 1'b0;
        pumpCnt <= 8'h00;
        chargePumpClk <= 1'b0;
    end
    else
    begin
        if (gateSupplyBelowReg)
            pumpOn <= 1'b1;
        else if (gateSupplyAboveHyst)
            pumpOn <= 1'b0;
        if (!pumpOn)
        begin
            pumpCnt <= 8'h00;
            chargePumpClk <= 1'b0;
        end
        else if (pumpCnt == `GDFP_PUMP_HALF_CYC - 1)
        begin
            pumpCnt <= 8'h00;
            chargePumpClk <= !chargePumpClk;
        end
        else
            pumpCnt <= pumpCnt + 8'h01;
    end
end

endmodule // gdfp_gate_driver_fault_protection
`default_nettype wire

// ### verification/gdfp_fault_asserts.sv
// port-level assertion checker for the fault protection block
`timescale 1ns/1ps
`default_nettype none
`include "gdfp_defines.vh"
module gdfp_fault_asserts
(
    input wire logic clk,
    input wire logic reset,
    input wire logic regRead,
    input wire logic [7:0] regReadData,
    input wire logic senseAmpOverThreshold,
    input wire logic gateSupplyBelowReg,
    input wire logic logicSupplyLow,
    input wire logic gate_supply_disable_level,
    input wire logic overcurrent_flag_out,
    input wire logic [2:0] upper_gate_out,
    input wire logic [2:0] lower_gate_out,
    input wire logic [2:0] activeOff,
    input wire logic holdOff,
    input wire logic chargePumpClk
);
    logic [7:0] pumpCnt;
    logic pumpArmed;
    logic [2:0] lsSeen;
    // ----------------------------------------------------------------
    // helper logic
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pumpCnt <= 8'h00;
            pumpArmed <= 1'b0;
            lsSeen <= 3'h0;
        end
        else
        begin
            lsSeen <= lsSeen | lower_gate_out;
            pumpCnt <= $changed(chargePumpClk) ? 8'h00 : pumpCnt + 8'h01;
            pumpArmed <= gateSupplyBelowReg && (pumpArmed || $changed(chargePumpClk));
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence pumpEdge;
        $changed(chargePumpClk) && pumpArmed;
    endsequence
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    AST_OC_FLAG: assert property (!$past(reset) |-> overcurrent_flag_out == $past(senseAmpOverThreshold))
        else $error("overcurrent flag not following comparator");
    AST_READ_IDLE: assert property (!$past(reset) && !$past(regRead) |-> regReadData == 8'h00)
        else $error("read data outside read answer cycle");
    AST_HOLDOFF: assert property ((logicSupplyLow || gate_supply_disable_level) |=> holdOff)
        else $error("hold-off missing");
    AST_RESET_SAFE: assert property (@(posedge clk) disable iff (1'b0) reset [*2] |->
        activeOff == 3'h7 && holdOff && upper_gate_out == 3'h0 && lower_gate_out == 3'h0)
        else $error("gates not safe in reset");
    AST_NO_SHOOT: assert property ((upper_gate_out & lower_gate_out) == 3'h0)
        else $error("both gates of a phase on");
    AST_DEADTIME: assert property ((upper_gate_out & ~$past(upper_gate_out) & $past(lower_gate_out, 2)) == 3'h0)
        else $error("upper gate on without deadtime");
    AST_HS_AFTER_LS: assert property ((upper_gate_out & ~lsSeen) == 3'h0)
        else $error("upper gate on before lower gate");
    AST_PUMP_HALF: assert property (pumpEdge |-> pumpCnt == `GDFP_PUMP_HALF_CYC - 1)
        else $error("pump half period wrong");
endmodule // gdfp_fault_asserts
bind gdfp_gate_driver_fault_protection gdfp_fault_asserts u_chk (.clk(clk), .reset(reset), .regRead(regRead),
    .regReadData(regReadData), .senseAmpOverThreshold(senseAmpOverThreshold),
    .gateSupplyBelowReg(gateSupplyBelowReg), .logicSupplyLow(logicSupplyLow),
    .gate_supply_disable_level(gate_supply_disable_level), .overcurrent_flag_out(overcurrent_flag_out),
    .upper_gate_out(upper_gate_out), .lower_gate_out(lower_gate_out), .activeOff(activeOff),
    .holdOff(holdOff), .chargePumpClk(chargePumpClk));
`default_nettype wire

// ### verification/gdfp_fet_model.sv
// behavioural model of the external power stage
`timescale 1ns/1ps
`default_nettype none
module gdfp_fet_model
(
    input wire logic clk,
    input wire logic [2:0] upperGate,
    input wire logic [2:0] lowerGate,
    input wire logic [2:0] shortGnd,
    input wire logic [2:0] stuckHigh,
    output logic [2:0] desatOut,
    output logic [2:0] nodeHigh
);
    initial
    begin
        desatOut = 3'h0;
        nodeHigh = 3'h0;
    end
    // undriven node wanders every cycle
    always @(posedge clk)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (stuckHigh[i])
                nodeHigh[i] <= 1'b1;
            else if (upperGate[i] && !shortGnd[i])
                nodeHigh[i] <= 1'b1;
            else if (lowerGate[i] || shortGnd[i])
                nodeHigh[i] <= 1'b0;
            else
                nodeHigh[i] <= ~nodeHigh[i];
            desatOut[i] <= upperGate[i] & shortGnd[i];
        end
    end
endmodule // gdfp_fet_model
`default_nettype wire

// ### verification/gdfp_gate_driver_fault_protection_bench.sv
// self-checking bench for the fault protection block
`timescale 1ns/1ps
`default_nettype none
`include "gdfp_defines.vh"
module gdfp_gate_driver_fault_protection_bench;
    logic clk, reset, regWrite, regRead, enableIn, senseAmpOverThreshold, gateSupplyUnder;
    logic gate_supply_disable_level, logicSupplyLow, gateSupplyBelowReg, gateSupplyAboveHyst;
    logic overcurrent_flag_out, irqOut, holdOff, chargePumpClk, lastPump;
    logic [3:0] regAddr;
    logic [7:0] regWriteData, regReadData;
    logic [2:0] upper_cmd_in, lower_cmd_in, desatComparator, phaseComparatorHigh, shortGnd, stuckHigh;
    logic [2:0] upper_gate_out, lower_gate_out, upperGateHighZ, activeOff;
    logic [31:0] seed;
    int err_count, total_checks, edges;
    gdfp_gate_driver_fault_protection DUT (.clk(clk), .reset(reset), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
        .upper_cmd_in(upper_cmd_in), .lower_cmd_in(lower_cmd_in), .enableIn(enableIn),
        .senseAmpOverThreshold(senseAmpOverThreshold), .desatComparator(desatComparator),
        .phaseComparatorHigh(phaseComparatorHigh), .gateSupplyUnder(gateSupplyUnder),
        .gate_supply_disable_level(gate_supply_disable_level), .logicSupplyLow(logicSupplyLow),
        .gateSupplyBelowReg(gateSupplyBelowReg), .gateSupplyAboveHyst(gateSupplyAboveHyst),
        .overcurrent_flag_out(overcurrent_flag_out), .irqOut(irqOut), .upper_gate_out(upper_gate_out),
        .lower_gate_out(lower_gate_out), .upperGateHighZ(upperGateHighZ), .activeOff(activeOff),
        .holdOff(holdOff), .chargePumpClk(chargePumpClk));
    gdfp_fet_model u_fets (.clk(clk), .upperGate(upper_gate_out), .lowerGate(lower_gate_out),
        .shortGnd(shortGnd), .stuckHigh(stuckHigh), .desatOut(desatComparator), .nodeHigh(phaseComparatorHigh));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] st(input logic oc, input logic de, input logic ph, input logic uv);
        return {4'h0, uv, ph, de, oc};
    endfunction
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rdchk(input string n, input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk(n, e & m, regReadData & m);
    endtask
    // host start-up: pulse every lower gate, then report initialization done
    task automatic doInit;
        @(posedge clk);
        lower_cmd_in <= 3'h7;
        cyc(4);
        lower_cmd_in <= 3'h0;
        wr(`GDFP_REG_CLEAR, 8'h04);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        #(40 * 20000);
        err_count++;
        print_verdict();
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial
    begin
        {reset, regWrite, regRead, enableIn, senseAmpOverThreshold, gateSupplyUnder} = 6'h20;
        {gate_supply_disable_level, logicSupplyLow, gateSupplyBelowReg, gateSupplyAboveHyst} = 4'h0;
        {regAddr, regWriteData, upper_cmd_in, lower_cmd_in, shortGnd, stuckHigh} = 24'h0;
        seed = 32'hd438aeb3;
        cyc(5);
        reset <= 1'b0;
        rdchk("status0", `GDFP_REG_STATUS0, st(0, 0, 0, 0), 8'hff);
        rdchk("mask", `GDFP_REG_MASK, `GDFP_MASK_RST, 8'hff);
        rdchk("ctrl", `GDFP_REG_CTRL, 8'h83, 8'h83);
        rdchk("deadtime", `GDFP_REG_TIMING, `GDFP_DEAD_RST, 8'hff);
        rdchk("unmapped", 4'hf, 8'h00, 8'hff);
        wr(`GDFP_REG_MASK, 8'h0f);
        wr(`GDFP_REG_TIMING, 8'h03);
        senseAmpOverThreshold <= 1'b1;
        cyc(3);
        #1 chk("irq oc", 8'h01, {7'h0, irqOut});
        rdchk("status oc", `GDFP_REG_STATUS0, st(1, 0, 0, 0), 8'h01);
        wr(`GDFP_REG_CLEAR, 8'h01);
        senseAmpOverThreshold <= 1'b0;
        cyc(3);
        #1 chk("irq held", 8'h01, {7'h0, irqOut});
        wr(`GDFP_REG_CLEAR, 8'h01);
        cyc(2);
        #1 chk("irq released", 8'h00, {7'h0, irqOut});
        wr(`GDFP_REG_MASK, 8'h0e);
        senseAmpOverThreshold <= 1'b1;
        cyc(3);
        senseAmpOverThreshold <= 1'b0;
        #1 chk("irq masked", 8'h00, {7'h0, irqOut});
        wr(`GDFP_REG_CLEAR, 8'h01);
        wr(`GDFP_REG_MASK, 8'h0f);
        enableIn <= 1'b1;
        doInit();
        rdchk("init done", `GDFP_REG_CTRL, 8'h00, 8'h80);
        for (int k = 0; k < 40; k++)
        begin
            @(posedge clk);
            seed = xs(seed);
            upper_cmd_in <= seed[2:0];
            lower_cmd_in <= seed[5:3] & ~seed[2:0];
            cyc(16 + seed[9:6]);
        end
        rdchk("no false faults", `GDFP_REG_STATUS0, st(0, 0, 0, 0), 8'h0f);
        @(posedge clk);
        upper_cmd_in <= 3'h1;
        lower_cmd_in <= 3'h0;
        cyc(20);
        #1 chk("upper on", 8'h01, {5'h0, upper_gate_out});
        shortGnd <= 3'h1;
        cyc(10);
        shortGnd <= 3'h0;
        rdchk("desat blip", `GDFP_REG_STATUS0, st(0, 0, 0, 0), 8'h02);
        shortGnd <= 3'h1;
        cyc(40);
        #1 chk("gates off", 8'h00, {2'h0, upper_gate_out, lower_gate_out});
        rdchk("desat", `GDFP_REG_STATUS0, st(0, 1, 0, 0), 8'h02);
        shortGnd <= 3'h0;
        upper_cmd_in <= 3'h0;
        wr(`GDFP_REG_CLEAR, 8'h03);
        cyc(2);
        #1 chk("irq group1", 8'h00, {7'h0, irqOut});
        rdchk("reinit needed", `GDFP_REG_CTRL, 8'h80, 8'h80);
        doInit();
        stuckHigh <= 3'h2;
        lower_cmd_in <= 3'h2;
        shortGnd <= 3'h1;
        upper_cmd_in <= 3'h1;
        cyc(25);
        rdchk("phase errs", `GDFP_REG_STATUS0, st(0, 1, 1, 0), 8'h06);
        rdchk("per-phase errs", `GDFP_REG_PHASEERR, 8'h03, 8'h07);
        {stuckHigh, shortGnd, upper_cmd_in, lower_cmd_in} <= 12'h0;
        wr(`GDFP_REG_CLEAR, 8'h03);
        doInit();
        gateSupplyUnder <= 1'b1;
        cyc(10);
        gateSupplyUnder <= 1'b0;
        rdchk("uv glitch", `GDFP_REG_STATUS0, st(0, 0, 0, 0), 8'h08);
        gateSupplyUnder <= 1'b1;
        cyc(100);
        #1 chk("uv active off", 8'h0e, {4'h0, activeOff, holdOff});
        cyc(150);
        #1 chk("uv hold-off", 8'h01, {7'h0, holdOff});
        gateSupplyUnder <= 1'b0;
        lower_cmd_in <= 3'h1;
        cyc(4);
        #1 chk("lower follows", 8'h01, {5'h0, lower_gate_out});
        chk("upper floats", 8'h01, {7'h0, upperGateHighZ[0]});
        lower_cmd_in <= 3'h0;
        wr(`GDFP_REG_CLEAR, 8'h01);
        gateSupplyBelowReg <= 1'b1;
        edges = 0;
        lastPump = chargePumpClk;
        repeat (300)
        begin
            @(posedge clk);
            edges += (chargePumpClk !== lastPump);
            lastPump = chargePumpClk;
        end
        chk("pump toggles", 8'h01, {7'h0, edges >= 2 && edges <= 4});
        gateSupplyBelowReg <= 1'b0;
        gateSupplyAboveHyst <= 1'b1;
        cyc(5);
        lastPump = chargePumpClk;
        cyc(200);
        #1 chk("pump stopped", 8'h00, {7'h0, chargePumpClk});
        logicSupplyLow <= 1'b1;
        cyc(3);
        #1 chk("hold-off supply", 8'h01, {7'h0, holdOff});
        logicSupplyLow <= 1'b0;
        gate_supply_disable_level <= 1'b1;
        cyc(3);
        #1 chk("hold-off disable", 8'h01, {7'h0, holdOff});
        gate_supply_disable_level <= 1'b0;
        reset <= 1'b1;
        cyc(3);
        #1 chk("hold-off reset", 8'h01, {7'h0, holdOff});
        reset <= 1'b0;
        cyc(3);
        print_verdict();
    end
endmodule // gdfp_gate_driver_fault_protection_bench
`default_nettype wire
